// ===== logic/high_port_pkg.sv
// Package for the upper-port GPIO bank: register offsets, reset values, field positions.
// Assumes an 8-bit special function register access port from the processor core.
package high_port_pkg;

  localparam logic [7:0] PORT3_DATA_ADDR = 8'hb0;
  localparam logic [7:0] PORT4_DATA_ADDR = 8'hc8;
  localparam logic [7:0] PORT5_DATA_ADDR = 8'hd8;
  localparam logic [7:0] PORT6_DATA_ADDR = 8'he8;
  localparam logic [7:0] PORT7_DATA_ADDR = 8'hf8;
  localparam logic [7:0] PORT3_MODE_ADDR = 8'ha7;
  localparam logic [7:0] PORT4_MODE_ADDR = 8'h9c;
  localparam logic [7:0] PORT5_MODE_ADDR = 8'h9d;
  localparam logic [7:0] PORT6_MODE_ADDR = 8'h9e;
  localparam logic [7:0] PORT7_MODE_ADDR = 8'h9f;
  localparam logic [7:0] XBAR0_ADDR = 8'he1;
  localparam logic [7:0] XBAR1_ADDR = 8'he2;
  localparam logic [7:0] XBAR2_ADDR = 8'he3;
  localparam logic [7:0] XBAR3_ADDR = 8'he4;

  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] XBAR_RESET = 8'h00;
  localparam logic [7:0] PORT4_PIN_MASK = 8'he0;
  localparam int WEAK_PULLUP_DISABLE_BIT = 7;
  localparam int NUM_PORTS = 5;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic rmw_read;
  } sfr_req_s;

  typedef struct packed {
    logic active;
    logic read_move;
    logic [7:0] oe_mask_p5;
    logic [7:0] oe_mask_p6;
    logic [7:0] oe_mask_p7;
    logic [7:0] out_p5;
    logic [7:0] out_p6;
    logic [7:0] out_p7;
  } ext_mem_s;

  typedef logic [NUM_PORTS*8-1:0] port_bus_t;

endpackage

// ===== logic/high_port_gpio_bank.sv
// Upper-port GPIO bank: data latches, output mode selects, crossbar settings and pin drive.
// Assumes a single-cycle SFR access port and an external memory interface on the same clock.
//
// Overview of operation
// - Port 3 latch drives only crossbar-free pins
// - Ordinary reads return synchronised pin levels
// - Read-modify-write reads return latch contents
// - Port 4 has pins only at bits 5-7
// - Ports 4 to 7 byte-addressable data registers
// - Registers and inputs work without pins present
// - Push-pull drives latch value both ways
// - Open-drain drives low, releases on one
// - Mode bit 1 push-pull, 0 open-drain
// - All pins open-drain after reset
// - Pull-ups on unless global disable bit set
// - Pull-up off while pin driven low
// - External memory overrides latches during moves
// - External reads release data-bus drivers
// - Port 5 carries upper address byte
`timescale 1ns/1ps

module high_port_gpio_bank
  import high_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire ext_mem_s ext_mem,
  input wire logic [7:0] periph_claim_p3,
  input wire logic [7:0] periph_out_p3,
  input wire port_bus_t pin_in,
  output port_bus_t pin_out,
  output port_bus_t pin_oe,
  output port_bus_t pullup_en
);

  typedef struct packed {
    logic [NUM_PORTS-1:0][7:0] latch;
    logic [NUM_PORTS-1:0][7:0] mode;
    logic [3:0][7:0] xbar;
    logic [NUM_PORTS-1:0][7:0] sync1;
    logic [NUM_PORTS-1:0][7:0] sync2;
    logic [7:0] rdata;
    logic hit;
  } state_s;

  state_s state_q;
  state_s state_d;
  logic [NUM_PORTS-1:0][7:0] drv_val;
  logic [NUM_PORTS-1:0][7:0] drv_en;
  logic [NUM_PORTS-1:0][7:0] pin_mask;

  // Returns the port index whose data register sits at the address, or NUM_PORTS on a miss.
  function automatic logic [2:0] data_index(input logic [7:0] a);
    case (a)
      PORT3_DATA_ADDR: data_index = 3'd0;
      PORT4_DATA_ADDR: data_index = 3'd1;
      PORT5_DATA_ADDR: data_index = 3'd2;
      PORT6_DATA_ADDR: data_index = 3'd3;
      PORT7_DATA_ADDR: data_index = 3'd4;
      default: data_index = 3'd5;
    endcase
  endfunction

  function automatic logic [2:0] mode_index(input logic [7:0] a);
    case (a)
      PORT3_MODE_ADDR: mode_index = 3'd0;
      PORT4_MODE_ADDR: mode_index = 3'd1;
      PORT5_MODE_ADDR: mode_index = 3'd2;
      PORT6_MODE_ADDR: mode_index = 3'd3;
      PORT7_MODE_ADDR: mode_index = 3'd4;
      default: mode_index = 3'd5;
    endcase
  endfunction

  function automatic logic [2:0] xbar_index(input logic [7:0] a);
    case (a)
      XBAR0_ADDR: xbar_index = 3'd0;
      XBAR1_ADDR: xbar_index = 3'd1;
      XBAR2_ADDR: xbar_index = 3'd2;
      XBAR3_ADDR: xbar_index = 3'd3;
      default: xbar_index = 3'd4;
    endcase
  endfunction

  // Per-port pin driver. The external memory interface only reaches ports 5 to 7,
  // so ports 3 and 4 see no override.
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_port
      logic [7:0] src_val;
      logic [7:0] external_memory_interface_mask;
      logic [7:0] external_memory_interface_val;
      logic [7:0] push_pull;
      always_comb
      begin
        external_memory_interface_mask = 8'h00;
        external_memory_interface_val = 8'h00;
        if (ext_mem.active)
        begin
          if (gp == 2)
          begin
            external_memory_interface_mask = ext_mem.oe_mask_p5;
            external_memory_interface_val = ext_mem.out_p5;
          end
          else if (gp == 3)
          begin
            external_memory_interface_mask = ext_mem.oe_mask_p6;
            external_memory_interface_val = ext_mem.out_p6;
          end
          else if (gp == 4)
          begin
            external_memory_interface_mask = ext_mem.oe_mask_p7;
            external_memory_interface_val = ext_mem.out_p7;
          end
        end
        src_val = (state_q.latch[gp] & ~external_memory_interface_mask) | (external_memory_interface_val & external_memory_interface_mask);
        push_pull = state_q.mode[gp];
        if (gp == 0)
        begin
          src_val = (src_val & ~periph_claim_p3) | (periph_out_p3 & periph_claim_p3);
        end
        drv_val[gp] = src_val;
        // Push-pull drives both levels, open-drain drives only a low.
        drv_en[gp] = push_pull | ~src_val;
        if (gp == 4 && ext_mem.active && ext_mem.read_move)
        begin
          drv_en[gp] = drv_en[gp] & ~external_memory_interface_mask;
        end
        pin_mask[gp] = (gp == 1) ? PORT4_PIN_MASK : 8'hff;
      end
      assign pin_out[gp*8 +: 8] = drv_val[gp] & pin_mask[gp];
      assign pin_oe[gp*8 +: 8] = drv_en[gp] & pin_mask[gp];
      // A pin pulling low never fights its own pull-up.
      assign pullup_en[gp*8 +: 8] = pin_mask[gp] &
        ~(drv_en[gp] & ~drv_val[gp]) &
        {8{~state_q.xbar[2][WEAK_PULLUP_DISABLE_BIT]}};
    end
  endgenerate

  always_comb
  begin
    logic [2:0] di;
    logic [2:0] mi;
    logic [2:0] xi;
    state_d = state_q;
    di = data_index(sfr_req.addr);
    mi = mode_index(sfr_req.addr);
    xi = xbar_index(sfr_req.addr);
    // Input paths stay live even when the package has no pins behind them.
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      state_d.sync1[p] = pin_in[p*8 +: 8];
      state_d.sync2[p] = state_q.sync1[p];
    end
    state_d.hit = 1'b0;
    state_d.rdata = state_q.rdata;
    if (sfr_req.rd_en)
    begin
      state_d.rdata = 8'h00;
      if (di < 3'd5)
      begin
        state_d.hit = 1'b1;
        if (sfr_req.rmw_read)
        begin
          state_d.rdata = state_q.latch[di];
        end
        else
        begin
          state_d.rdata = state_q.sync2[di];
        end
      end
      else if (mi < 3'd5)
      begin
        state_d.hit = 1'b1;
        state_d.rdata = state_q.mode[mi];
      end
      else if (xi < 3'd4)
      begin
        state_d.hit = 1'b1;
        state_d.rdata = state_q.xbar[xi[1:0]];
      end
    end
    if (sfr_req.wr_en)
    begin
      if (di < 3'd5)
      begin
        state_d.latch[di] = sfr_req.wdata;
        state_d.hit = 1'b1;
      end
      else if (mi < 3'd5)
      begin
        state_d.mode[mi] = sfr_req.wdata;
        state_d.hit = 1'b1;
      end
      else if (xi < 3'd4)
      begin
        state_d.xbar[xi[1:0]] = sfr_req.wdata;
        state_d.hit = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        state_q.latch[p] <= LATCH_RESET;
        state_q.mode[p] <= MODE_RESET;
        state_q.sync1[p] <= 8'h00;
        state_q.sync2[p] <= 8'h00;
      end
      for (int x = 0; x < 4; x++)
      begin
        state_q.xbar[x] <= XBAR_RESET;
      end
      state_q.rdata <= 8'h00;
      state_q.hit <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign sfr_rdata = state_q.rdata;
  assign sfr_hit = state_q.hit;

endmodule

// ===== testbench/high_port_monitor.sv
// Checker for the upper-port GPIO bank; it sees the bank's ports only.
// Assumes the bind at the foot of this file and a reset that sets the bank's latches high and its modes to open-drain.
`timescale 1ns/1ps
module high_port_monitor
  import high_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire sfr_req_s sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire ext_mem_s ext_mem,
  input wire logic [7:0] periph_claim_p3,
  input wire logic [7:0] periph_out_p3,
  input wire port_bus_t pin_in,
  input wire port_bus_t pin_out,
  input wire port_bus_t pin_oe,
  input wire port_bus_t pullup_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence pin_rd;
    sfr_req.rd_en && !sfr_req.wr_en && !sfr_req.rmw_read && sfr_req.addr == PORT7_DATA_ADDR;
  endsequence
  sequence latch_rd;
    sfr_req.rd_en && sfr_req.rmw_read && !ext_mem.active && sfr_req.addr == PORT5_DATA_ADDR;
  endsequence
  a_pin_read_sync: assert property (pin_rd |=> sfr_rdata == $past(pin_in[39:32], 3))
    else $error("pin read wrong");
  a_rmw_latch_read: assert property (latch_rd |=> sfr_rdata == $past(pin_out[23:16]))
    else $error("latch read wrong");
  a_claim_route: assert property (((pin_out[7:0] ^ periph_out_p3) & periph_claim_p3) == 8'h00)
    else $error("claimed pin wrong");
  a_port4_unpinned: assert property ({pin_out[12:8], pin_oe[12:8], pullup_en[12:8]} == 15'h0)
    else $error("port4 gap driven");
  a_pullup_yield: assert property ((pullup_en & pin_oe & ~pin_out) == 40'h0)
    else $error("pullup on low pin");
  a_pullup_kill: assert property (sfr_req.wr_en && sfr_req.addr == XBAR2_ADDR && sfr_req.wdata[7]
    |=> pullup_en == 40'h0) else $error("pullups not off");
  a_reset_open: assert property ($rose(reset_n) |-> pin_oe == 40'h0)
    else $error("driver on at reset");
  a_ext_override: assert property (ext_mem.active |-> ((pin_out[23:16] ^ ext_mem.out_p5)
    & ext_mem.oe_mask_p5) == 8'h00) else $error("override lost");
  a_ext_release: assert property (ext_mem.active && ext_mem.read_move |->
    (pin_oe[39:32] & ext_mem.oe_mask_p7) == 8'h00) else $error("bus not released");
  a_unmapped_quiet: assert property (sfr_req.rd_en && sfr_req.addr == 8'h00 |=> !sfr_hit)
    else $error("unmapped hit");
endmodule
bind high_port_gpio_bank high_port_monitor mon_u (.*);

// ===== testbench/pin_board_model.sv
// Board model: resolves each pin from the bank's driver, pull-up and an outside device.
// Assumes outside devices only drive where the bank leaves the pin undriven.
`timescale 1ns/1ps
module pin_board_model
  import high_port_pkg::*;
(
  input wire logic sys_clk,
  input wire port_bus_t pin_out,
  input wire port_bus_t pin_oe,
  input wire port_bus_t pullup_en,
  input wire port_bus_t ext_drv,
  input wire port_bus_t ext_en,
  output port_bus_t pin_lvl
);
  port_bus_t last_q = '0;
  // An undriven pin with no pull-up flips each cycle, so a floating read cannot pass by luck.
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv)
    | (~pin_oe & ~ext_en & (pullup_en | ~last_q));
  always_ff @(posedge sys_clk) last_q <= pin_lvl;
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the upper-port GPIO bank with a board model on its pins.
// Assumes the bank answers each register access one cycle after the request.
`timescale 1ns/1ps
module tb_top;
  import high_port_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  sfr_req_s sfr_req = '0;
  ext_mem_s ext_mem = '0;
  logic [7:0] claim = 8'h00;
  logic [7:0] pout3 = 8'h00;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  port_bus_t pin_lvl, pin_out, pin_oe, pullup_en;
  port_bus_t ext_drv = '0;
  port_bus_t ext_en = '0;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] dat_a[5] = '{PORT3_DATA_ADDR, PORT4_DATA_ADDR, PORT5_DATA_ADDR, PORT6_DATA_ADDR,
    PORT7_DATA_ADDR};
  logic [7:0] mod_a[5] = '{PORT3_MODE_ADDR, PORT4_MODE_ADDR, PORT5_MODE_ADDR, PORT6_MODE_ADDR,
    PORT7_MODE_ADDR};
  // Each row is port index, mode byte, latch byte.
  logic [7:0] rows[5][3] = '{'{8'h00, 8'h0f, 8'h55}, '{8'h01, 8'hf0, 8'h3c},
    '{8'h02, 8'hff, 8'h00}, '{8'h03, 8'h81, 8'hff}, '{8'h04, 8'h00, 8'ha5}};
  high_port_gpio_bank dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .ext_mem(ext_mem), .periph_claim_p3(claim),
    .periph_out_p3(pout3), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en));
  pin_board_model board_u (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_drv(ext_drv), .ext_en(ext_en), .pin_lvl(pin_lvl));
  task automatic wrap_up;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // An idle edge follows each request so that back-to-back calls never drive the bus twice at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{addr: a, wdata: d, wr_en: 1'b1, rd_en: 1'b0, rmw_read: 1'b0};
    @(posedge sys_clk);
    #1 sfr_req = '0;
    @(posedge sys_clk);
    #1;
  endtask
  // Returns the hit flag above the read byte.
  task automatic rd(input logic [7:0] a, input logic rmw, output logic [8:0] r);
    sfr_req = '{addr: a, wdata: 8'h00, wr_en: 1'b0, rd_en: 1'b1, rmw_read: rmw};
    @(posedge sys_clk);
    #1 sfr_req = '0;
    r = {sfr_hit, sfr_rdata};
    @(posedge sys_clk);
    #1;
  endtask
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    #1000000 bad_count++;
    wrap_up();
  end
  initial
  begin
    logic [8:0] r;
    logic [7:0] m;
    repeat (6) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    chk(pin_oe, 40'h0);
    chk(pullup_en, 40'hffffffe0ff);
    foreach (rows[i])
    begin
      m = (rows[i][0] == 8'h01) ? PORT4_PIN_MASK : 8'hff;
      wr(mod_a[rows[i][0]], rows[i][1]);
      wr(dat_a[rows[i][0]], rows[i][2]);
      repeat (3) @(posedge sys_clk);
      #1 chk(40'(pin_oe[8*rows[i][0] +: 8]), 40'((rows[i][1] | ~rows[i][2]) & m));
      rd(dat_a[rows[i][0]], 1'b0, r);
      chk(40'(r & {1'b1, m}), 40'({1'b1, rows[i][2] & m}));
      rd(dat_a[rows[i][0]], 1'b1, r);
      chk(40'(r & {1'b1, m}), 40'({1'b1, rows[i][2] & m}));
    end
    chk(40'({pullup_en[39:32], pullup_en[23:16]}), 40'ha500);
    wr(PORT4_DATA_ADDR, 8'h00);
    chk(40'(pin_oe[15:8]), 40'he0);
    wr(XBAR2_ADDR, 8'h80);
    chk(pullup_en, 40'h0);
    wr(XBAR2_ADDR, 8'h00);
    wr(PORT6_MODE_ADDR, 8'h00);
    ext_en[31:24] = 8'hc3;
    repeat (3) @(posedge sys_clk);
    #1 rd(PORT6_DATA_ADDR, 1'b0, r);
    chk(40'(r), 40'h13c);
    rd(PORT6_DATA_ADDR, 1'b1, r);
    chk(40'(r), 40'h1ff);
    ext_en = '0;
    claim = 8'hf0;
    pout3 = 8'ha0;
    #5 chk(40'(pin_out[7:0]), 40'ha5);
    @(posedge sys_clk);
    #1 wr(PORT7_MODE_ADDR, 8'hff);
    claim = 8'h00;
    ext_mem = '{active: 1'b1, read_move: 1'b1, oe_mask_p5: 8'hff, oe_mask_p7: 8'hff,
      out_p5: 8'h12, default: '0};
    #5 chk(40'(pin_out[23:16]), 40'h12);
    chk(40'({pin_oe[39:32], pin_oe[23:16]}), 40'h00ff);
    @(posedge sys_clk);
    #1 ext_mem = '0;
    rd(8'h00, 1'b0, r);
    chk(40'(r), 40'h0);
    wrap_up();
  end
endmodule
